// [hw/ptrlp_pkg.sv]
package ptrlp_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0]  OFF_LOOP_CNT   = 8'h00;
    localparam logic [7:0]  OFF_FRAME_DISP = 8'h04;
    localparam logic [7:0]  OFF_PTR_CTRL   = 8'h08;
    localparam logic [7:0]  OFF_FRAME_BASE = 8'h0C;
    localparam logic [7:0]  OFF_PTR_STATUS = 8'h10;

    // Reset values
    localparam logic [15:0] RST_LOOP_CNT   = 16'h0000;
    localparam logic [7:0]  RST_FRAME_DISP = 8'h00;
    localparam logic [15:0] RST_PTR_CTRL   = 16'h001C;
    localparam logic [15:0] RST_FRAME_BASE = 16'h0000;

    // Pointer control field positions
    localparam int SRC_SEL_LSB   = 0;
    localparam int WBS_ZERO_BIT  = 2;
    localparam int WBS_ONE_BIT   = 3;
    localparam int WBS_FRAME_BIT = 4;
    localparam int CTRL_USED_MSB = 4;

    // Status register field positions
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_SEL_LSB    = 1;
    localparam int STAT_WORD_BIT   = 3;

    // Source select codes
    localparam logic [1:0] SEL_DP_ZERO = 2'h0;
    localparam logic [1:0] SEL_DP_ONE  = 2'h1;
    localparam logic [1:0] SEL_FRAME   = 2'h2;
    localparam logic [1:0] SEL_RSVD    = 2'h3;

    // Target of an instruction register write
    typedef enum logic [2:0] {
        TGT_NONE       = 3'b000,
        TGT_DP_ZERO    = 3'b001,
        TGT_DP_ONE     = 3'b010,
        TGT_FRAME_BASE = 3'b011,
        TGT_FRAME_DISP = 3'b100,
        TGT_PTR_CTRL   = 3'b101,
        TGT_LOOP_CNT   = 3'b110
    } ptrlp_target_t;

    // One core request per cycle
    typedef struct packed {
        logic          loop_pass;   // Loop pass completed
        logic          fp_access;   // Frame pointer access with stepping
        logic          fp_write;    // 1 write (pre-step), 0 read (post-step)
        logic          step_down;   // 1 decrement, 0 increment
        ptrlp_target_t wr_target;
        logic [15:0]   wr_data;
    } ptrlp_core_req_t;

    // APB response bundle
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ptrlp_apb_rsp_t;

endpackage : ptrlp_pkg

// [hw/ptrlp_frame_step.sv]
`timescale 1ns/10ps
`default_nettype none

module ptrlp_frame_step (
    // Frame registers
    input  wire logic [15:0] base_in,
    input  wire logic [7:0]  disp_in,
    // Step control
    input  wire logic        write_in,
    input  wire logic        down_in,
    // Results
    output logic      [7:0]  disp_step_out,
    output logic      [15:0] addr_now_out,
    output logic      [15:0] addr_access_out
);

    logic [7:0] stepped;

    // Stepped displacement, wraps in 8 bits
    assign stepped       = down_in ? disp_in - 8'h01 : disp_in + 8'h01;
    assign disp_step_out = stepped;

    // Unsigned base plus displacement
    assign addr_now_out = base_in + {8'h00, disp_in};

    // Write uses stepped value, read uses old value
    assign addr_access_out = write_in ? base_in + {8'h00, stepped}
                                      : addr_now_out;

endmodule : ptrlp_frame_step

`default_nettype wire

// [hw/ptrlp_regs.sv]
// Function
// - Second loop counter is 16 bits, cleared to zero by any reset.
// - Each completed loop pass decrements the second loop counter by one.
// - Second loop counter value serves as branch loop-control condition.
// - Frame displacement is 8 bits, cleared to zero by any reset.
// - Frame pointer equals unsigned sum of frame base and displacement.
// - Stepped frame pointer write adjusts displacement before the access.
// - Stepped frame pointer read adjusts displacement after the access.
// - Pointer control is 16 bits, reset value 001Ch.
// - Control bits 1:0 choose load source: 00 dp0, 01 dp1, 10 frame.
// - Reserved select code 11 acts as frame pointer selection.
// - Writing a pointer or control register makes that pointer the active source.
// - Auto stepping never changes select bits nor activates the pointer.
// - Control bits 2,3,4 set word mode for dp0, dp1, frame pointer.
// - Control bits 15 to 5 are reserved and read zero.
`timescale 1ns/10ps
`default_nettype none

module ptrlp_regs (
    // Clock and reset
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_n_in,
    // APB slave
    input  wire logic                      psel_in,
    input  wire logic                      penable_in,
    input  wire logic                      pwrite_in,
    input  wire logic [7:0]                paddr_in,
    input  wire logic [31:0]               pwdata_in,
    output logic                           pready_out,
    output logic                           pslverr_out,
    output logic      [31:0]               prdata_out,
    // Core requests
    input  wire ptrlp_pkg::ptrlp_core_req_t core_req_in,
    // Core view of the registers
    output logic      [15:0]               loop_count_out,
    output logic                           loop_nonzero_out,
    output logic      [15:0]               frame_pointer_out,
    output logic      [15:0]               fp_access_addr_out,
    output logic      [1:0]                source_sel_out,
    output logic                           source_active_out,
    output logic                           source_word_out
);

    localparam int CTRL_W = ptrlp_pkg::CTRL_USED_MSB + 1;

    // All module state
    typedef struct packed {
        logic [15:0]             loop_cnt;
        logic [7:0]              disp;
        logic [15:0]             base;
        logic [CTRL_W-1:0]       ctrl;
        logic                    active;
        logic [15:0]             fp;
        logic [15:0]             fp_addr;
        logic                    loop_nz;
        logic [1:0]              eff_sel;
        logic                    eff_word;
        ptrlp_pkg::ptrlp_apb_rsp_t rsp;
    } ptrlp_state_t;

    ptrlp_state_t state_r;
    ptrlp_state_t state_nxt;

    logic        apb_access;
    logic        apb_commit;
    logic        apb_wr;
    logic        apb_mapped;
    logic [7:0]  disp_step;
    logic [15:0] addr_now;
    logic [15:0] addr_access;
    logic [15:0] ctrl_full;
    logic [15:0] status_word;

    // Frame pointer arithmetic
    ptrlp_frame_step u_step (
        .base_in         (state_r.base),
        .disp_in         (state_r.disp),
        .write_in        (core_req_in.fp_write),
        .down_in         (core_req_in.step_down),
        .disp_step_out   (disp_step),
        .addr_now_out    (addr_now),
        .addr_access_out (addr_access)
    );

    // APB phase decode
    assign apb_access = psel_in & penable_in;
    assign apb_commit = apb_access & state_r.rsp.pready;
    assign apb_wr     = apb_commit & pwrite_in & apb_mapped;

    // Address map check
    always_comb begin
        case (paddr_in)
            ptrlp_pkg::OFF_LOOP_CNT,
            ptrlp_pkg::OFF_FRAME_DISP,
            ptrlp_pkg::OFF_PTR_CTRL,
            ptrlp_pkg::OFF_FRAME_BASE,
            ptrlp_pkg::OFF_PTR_STATUS: apb_mapped = 1'b1;
            default:                   apb_mapped = 1'b0;
        endcase
    end

    // Control readback, upper bits zero
    assign ctrl_full = {{(16 - CTRL_W){1'b0}}, state_r.ctrl};

    // Status readback
    assign status_word = {12'h000, state_r.eff_word, state_r.eff_sel, state_r.active};

    // Next state
    always_comb begin
        state_nxt = state_r;

        // Loop pass countdown
        if (core_req_in.loop_pass) begin
            state_nxt.loop_cnt = state_r.loop_cnt - 16'h0001;
        end

        // Frame pointer stepping, select bits untouched
        if (core_req_in.fp_access) begin
            state_nxt.disp    = disp_step;
            state_nxt.fp_addr = addr_access;
        end

        // Instruction writes activate their pointer
        case (core_req_in.wr_target)
            ptrlp_pkg::TGT_DP_ZERO: begin
                state_nxt.ctrl[1:0] = ptrlp_pkg::SEL_DP_ZERO;
                state_nxt.active    = 1'b1;
            end
            ptrlp_pkg::TGT_DP_ONE: begin
                state_nxt.ctrl[1:0] = ptrlp_pkg::SEL_DP_ONE;
                state_nxt.active    = 1'b1;
            end
            ptrlp_pkg::TGT_FRAME_BASE: begin
                state_nxt.base      = core_req_in.wr_data;
                state_nxt.ctrl[1:0] = ptrlp_pkg::SEL_FRAME;
                state_nxt.active    = 1'b1;
            end
            ptrlp_pkg::TGT_FRAME_DISP: begin
                state_nxt.disp      = core_req_in.wr_data[7:0];
                state_nxt.ctrl[1:0] = ptrlp_pkg::SEL_FRAME;
                state_nxt.active    = 1'b1;
            end
            ptrlp_pkg::TGT_PTR_CTRL: begin
                state_nxt.ctrl   = core_req_in.wr_data[CTRL_W-1:0];
                state_nxt.active = 1'b1;
            end
            ptrlp_pkg::TGT_LOOP_CNT: begin
                state_nxt.loop_cnt = core_req_in.wr_data;
            end
            default: begin
            end
        endcase

        // Software writes land last
        if (apb_wr) begin
            case (paddr_in)
                ptrlp_pkg::OFF_LOOP_CNT: begin
                    state_nxt.loop_cnt = pwdata_in[15:0];
                end
                ptrlp_pkg::OFF_FRAME_DISP: begin
                    state_nxt.disp      = pwdata_in[7:0];
                    state_nxt.ctrl[1:0] = ptrlp_pkg::SEL_FRAME;
                    state_nxt.active    = 1'b1;
                end
                ptrlp_pkg::OFF_PTR_CTRL: begin
                    state_nxt.ctrl   = pwdata_in[CTRL_W-1:0];
                    state_nxt.active = 1'b1;
                end
                ptrlp_pkg::OFF_FRAME_BASE: begin
                    state_nxt.base      = pwdata_in[15:0];
                    state_nxt.ctrl[1:0] = ptrlp_pkg::SEL_FRAME;
                    state_nxt.active    = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Registered views of the new values
        state_nxt.fp      = state_nxt.base + {8'h00, state_nxt.disp};
        state_nxt.loop_nz = (state_nxt.loop_cnt != 16'h0000);
        if (!core_req_in.fp_access) begin
            state_nxt.fp_addr = state_nxt.fp;
        end

        // Source decode, reserved code maps to frame
        case (state_nxt.ctrl[1:0])
            ptrlp_pkg::SEL_DP_ZERO: begin
                state_nxt.eff_sel  = ptrlp_pkg::SEL_DP_ZERO;
                state_nxt.eff_word = state_nxt.ctrl[ptrlp_pkg::WBS_ZERO_BIT];
            end
            ptrlp_pkg::SEL_DP_ONE: begin
                state_nxt.eff_sel  = ptrlp_pkg::SEL_DP_ONE;
                state_nxt.eff_word = state_nxt.ctrl[ptrlp_pkg::WBS_ONE_BIT];
            end
            default: begin
                state_nxt.eff_sel  = ptrlp_pkg::SEL_FRAME;
                state_nxt.eff_word = state_nxt.ctrl[ptrlp_pkg::WBS_FRAME_BIT];
            end
        endcase

        // APB answer after one wait state
        state_nxt.rsp.pready  = apb_access & ~state_r.rsp.pready;
        state_nxt.rsp.pslverr = apb_access & ~state_r.rsp.pready & ~apb_mapped;
        state_nxt.rsp.prdata  = 32'h0000_0000;
        if (apb_access && !state_r.rsp.pready && !pwrite_in) begin
            case (paddr_in)
                ptrlp_pkg::OFF_LOOP_CNT:   state_nxt.rsp.prdata = {16'h0000, state_r.loop_cnt};
                ptrlp_pkg::OFF_FRAME_DISP: state_nxt.rsp.prdata = {24'h000000, state_r.disp};
                ptrlp_pkg::OFF_PTR_CTRL:   state_nxt.rsp.prdata = {16'h0000, ctrl_full};
                ptrlp_pkg::OFF_FRAME_BASE: state_nxt.rsp.prdata = {16'h0000, state_r.base};
                ptrlp_pkg::OFF_PTR_STATUS: state_nxt.rsp.prdata = {16'h0000, status_word};
                default:                   state_nxt.rsp.prdata = 32'h0000_0000;
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_r.loop_cnt    <= ptrlp_pkg::RST_LOOP_CNT;
            state_r.disp        <= ptrlp_pkg::RST_FRAME_DISP;
            state_r.base        <= ptrlp_pkg::RST_FRAME_BASE;
            state_r.ctrl        <= ptrlp_pkg::RST_PTR_CTRL[CTRL_W-1:0];
            state_r.active      <= 1'b0;
            state_r.fp          <= ptrlp_pkg::RST_FRAME_BASE;
            state_r.fp_addr     <= ptrlp_pkg::RST_FRAME_BASE;
            state_r.loop_nz     <= 1'b0;
            state_r.eff_sel     <= ptrlp_pkg::SEL_DP_ZERO;
            state_r.eff_word    <= ptrlp_pkg::RST_PTR_CTRL[ptrlp_pkg::WBS_ZERO_BIT];
            state_r.rsp.pready  <= 1'b0;
            state_r.rsp.pslverr <= 1'b0;
            state_r.rsp.prdata  <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from state
    assign pready_out         = state_r.rsp.pready;
    assign pslverr_out        = state_r.rsp.pslverr;
    assign prdata_out         = state_r.rsp.prdata;
    assign loop_count_out     = state_r.loop_cnt;
    assign loop_nonzero_out   = state_r.loop_nz;
    assign frame_pointer_out  = state_r.fp;
    assign fp_access_addr_out = state_r.fp_addr;
    assign source_sel_out     = state_r.eff_sel;
    assign source_active_out  = state_r.active;
    assign source_word_out    = state_r.eff_word;

endmodule : ptrlp_regs

`default_nettype wire

// [tb/ptrlp_properties.sv]
`timescale 1ns/10ps
`default_nettype none

module ptrlp_chk (
    // Clock and reset
    input wire logic                       core_clk_in,
    input wire logic                       rst_n_in,
    // APB
    input wire logic                       psel_in,
    input wire logic                       penable_in,
    input wire logic                       pwrite_in,
    input wire logic [7:0]                 paddr_in,
    input wire logic                       pready_out,
    input wire logic                       pslverr_out,
    input wire logic [31:0]                prdata_out,
    // Core side
    input wire ptrlp_pkg::ptrlp_core_req_t core_req_in,
    input wire logic [15:0]                loop_count_out,
    input wire logic                       loop_nonzero_out,
    input wire logic [15:0]                frame_pointer_out,
    input wire logic [15:0]                fp_access_addr_out,
    input wire logic [1:0]                 source_sel_out,
    input wire logic                       source_active_out
);
    // Write activity on either path
    logic apbw;
    logic q;
    assign apbw = psel_in && penable_in && pwrite_in;
    assign q    = !apbw && (core_req_in.wr_target == ptrlp_pkg::TGT_NONE);

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("pready late");
    a_apb_err_map: assert property (pready_out |->
        pslverr_out == !(paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
        else $error("pslverr wrong");
    a_rdata_idle: assert property (!pready_out || pwrite_in |-> prdata_out == 32'h0)
        else $error("prdata not idle");
    a_loop_dec: assert property (core_req_in.loop_pass && q
        |=> loop_count_out == $past(loop_count_out) - 16'h1) else $error("loop step");
    a_loop_flag: assert property (loop_nonzero_out == (loop_count_out != 16'h0))
        else $error("loop flag");
    a_fp_post_read: assert property (core_req_in.fp_access && !core_req_in.fp_write && q
        |=> fp_access_addr_out == $past(frame_pointer_out)) else $error("read step");
    a_fp_pre_write: assert property (core_req_in.fp_access && core_req_in.fp_write && q
        |=> fp_access_addr_out == frame_pointer_out
        && frame_pointer_out != $past(frame_pointer_out)) else $error("write step");
    a_step_keeps_sel: assert property (core_req_in.fp_access && q
        |=> $stable(source_sel_out) && $stable(source_active_out)) else $error("step sel");
    a_addr_idle: assert property (!core_req_in.fp_access
        |=> fp_access_addr_out == frame_pointer_out) else $error("addr idle");
    a_ctrl_sel: assert property (core_req_in.wr_target == ptrlp_pkg::TGT_PTR_CTRL && !apbw
        |=> source_active_out && source_sel_out == ($past(core_req_in.wr_data[1]) ?
        2'h2 : $past(core_req_in.wr_data[1:0]))) else $error("ctrl sel");
    a_frame_sel: assert property (!apbw && core_req_in.wr_target inside
        {ptrlp_pkg::TGT_FRAME_BASE, ptrlp_pkg::TGT_FRAME_DISP}
        |=> source_sel_out == 2'h2 && source_active_out) else $error("frame sel");
endmodule : ptrlp_chk

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, lnz, act, wrd;
    logic [15:0] lc, fp, fpa;
    logic [1:0] sel, es;
    ptrlp_pkg::ptrlp_core_req_t req = '0;
    int n_errors = 0, num_checks = 0;

    // Clock
    always #12.5 clk = ~clk;

    ptrlp_regs uut (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .pslverr_out(pslverr), .prdata_out(prdata), .core_req_in(req), .loop_count_out(lc),
        .loop_nonzero_out(lnz), .frame_pointer_out(fp), .fp_access_addr_out(fpa),
        .source_sel_out(sel), .source_active_out(act), .source_word_out(wrd));

    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer, bounded wait for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        #1;
        if (k >= 20) begin
            n_errors++;
            finish_test();
        end
    endtask : apb

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'h0, a, 32'h0);
        chk(nm, e, rd);
        chk({nm, " err"}, {31'h0, ee}, {31'h0, err});
    endtask : rdc

    // Core request held for cyc edges
    task core(input logic [3:0] f, input ptrlp_pkg::ptrlp_target_t t, input logic [15:0] d,
              input int cyc);
        @(posedge clk);
        req <= {f, t, d};
        repeat (cyc) @(posedge clk);
        req <= '0;
        #1;
    endtask : core

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        chk("active", 32'h0, {31'h0, act});
        chk("word", 32'h1, {31'h0, wrd});
        rdc("loop", 8'h00, 32'h0, 1'h0);
        rdc("disp", 8'h04, 32'h0, 1'h0);
        rdc("ctrl", 8'h08, 32'h1C, 1'h0);
        rdc("stat", 8'h10, 32'h8, 1'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            es = (i == 3) ? 2'h2 : 2'(i);
            apb(1'h1, 8'h08, 32'hFFFFFFE0 | 32'(i) | ((i % 2) ? (32'h4 << es) : 32'h0));
            chk("sel", {30'h0, es}, {30'h0, sel});
            chk("word", 32'(i % 2), {31'h0, wrd});
            rdc("ctrl", 8'h08, 32'(i) | ((i % 2) ? (32'h4 << es) : 32'h0), 1'h0);
        end
        chk("active", 32'h1, {31'h0, act});
        $display("test control done");
        apb(1'h1, 8'h00, 32'h2);
        core(4'h8, ptrlp_pkg::TGT_NONE, 16'h0, 2);
        chk("loop", 32'h0, {16'h0, lc});
        chk("nz", 32'h0, {31'h0, lnz});
        core(4'h8, ptrlp_pkg::TGT_NONE, 16'h0, 1);
        chk("nz", 32'h1, {31'h0, lnz});
        rdc("loop", 8'h00, 32'hFFFF, 1'h0);
        $display("test loop done");
        apb(1'h1, 8'h0C, 32'h1000);
        apb(1'h1, 8'h04, 32'hFF);
        chk("fp", 32'h10FF, {16'h0, fp});
        apb(1'h1, 8'h08, 32'h1);
        core(4'h4, ptrlp_pkg::TGT_NONE, 16'h0, 1);
        chk("fpa", 32'h10FF, {16'h0, fpa});
        chk("fp", 32'h1000, {16'h0, fp});
        core(4'h7, ptrlp_pkg::TGT_NONE, 16'h0, 1);
        chk("fpa", 32'h10FF, {16'h0, fpa});
        chk("sel", 32'h1, {30'h0, sel});
        $display("test frame done");
        core(4'h0, ptrlp_pkg::TGT_FRAME_DISP, 16'h10, 1);
        chk("fp", 32'h1010, {16'h0, fp});
        core(4'h0, ptrlp_pkg::TGT_DP_ZERO, 16'h0, 1);
        chk("sel", 32'h0, {30'h0, sel});
        core(4'h0, ptrlp_pkg::TGT_FRAME_BASE, 16'h2000, 1);
        chk("sel", 32'h2, {30'h0, sel});
        core(4'h0, ptrlp_pkg::TGT_DP_ONE, 16'h0, 1);
        chk("sel", 32'h1, {30'h0, sel});
        core(4'h0, ptrlp_pkg::TGT_PTR_CTRL, 16'hFF03, 1);
        rdc("ctrl", 8'h08, 32'h3, 1'h0);
        core(4'h0, ptrlp_pkg::TGT_LOOP_CNT, 16'h5, 1);
        rdc("loop", 8'h00, 32'h5, 1'h0);
        rdc("hole", 8'h14, 32'h0, 1'h1);
        apb(1'h1, 8'h20, 32'h7);
        chk("hole err", 32'h1, {31'h0, err});
        rdc("stat", 8'h10, 32'h5, 1'h0);
        $display("test instr done");
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        chk("loop", 32'h0, {16'h0, lc});
        chk("fp", 32'h0, {16'h0, fp});
        chk("active", 32'h0, {31'h0, act});
        rdc("ctrl", 8'h08, 32'h1C, 1'h0);
        rdc("disp", 8'h04, 32'h0, 1'h0);
        $display("test rerun done");
        finish_test();
    end
endmodule : tb_top

bind ptrlp_regs ptrlp_chk u_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
    .core_req_in(core_req_in), .loop_count_out(loop_count_out),
    .loop_nonzero_out(loop_nonzero_out), .frame_pointer_out(frame_pointer_out),
    .fp_access_addr_out(fp_access_addr_out), .source_sel_out(source_sel_out),
    .source_active_out(source_active_out));

`default_nettype wire
